//--- inc/squ_defs.svh
/*
  Constants of the signed quotient unit: instruction fields, register map,
  field positions, reset values and iteration counts.
  Assumes instructions numbered with bit 0 as the most significant bit.
*/
`ifndef SQU_DEFS_SVH
`define SQU_DEFS_SVH

// Instruction fields, as slices of a 32-bit word (word bit 31 = field bit 0)
`define SQU_PRIMARY_HI     31
`define SQU_PRIMARY_LO     26
`define SQU_TARGET_HI      25
`define SQU_TARGET_LO      21
`define SQU_OVF_EN_BIT     10
`define SQU_EXT_HI         9
`define SQU_EXT_LO         1
`define SQU_RECORD_BIT     0
`define SQU_PRIMARY_DIV    6'h1f
`define SQU_EXT_LEGACY     9'h14b
`define SQU_EXT_DWORD      9'h1e9

// APB register byte offsets
`define SQU_ADDR_CTRL      8'h00
`define SQU_ADDR_STATUS    8'h04
`define SQU_ADDR_MASK      8'h08
`define SQU_ADDR_MQ        8'h0c
`define SQU_ADDR_FLAGS     8'h10
`define SQU_ADDR_RES_LO    8'h14
`define SQU_ADDR_RES_HI    8'h18

// Field positions
`define SQU_CTRL_IMPL64    0
`define SQU_EV_DONE        0
`define SQU_EV_OVF         1
`define SQU_EV_ILLEGAL     2
`define SQU_FL_SO          0
`define SQU_FL_OV          1
`define SQU_FL_CA          2
`define SQU_FL_CR0_LO      8
`define SQU_FL_CR0_HI      11

// Reset values
`define SQU_RST_IMPL64     1'b1
`define SQU_RST_MASK       3'h0

// Datapath figures
`define SQU_DIV_LAST       7'h3f
`define SQU_MIN_WORD       32'h8000_0000
`define SQU_MIN_DWORD      64'h8000_0000_0000_0000
`define SQU_ALL_ONES       64'hffff_ffff_ffff_ffff

`endif

//--- inc/squ_pkg.sv
/*
  Types of the signed quotient unit: issue and result carriers, decode
  fields, controller states and the divider state record.
  Assumes squ_defs.svh is on the include path.
*/
package squ_pkg;

  typedef enum logic [2:0] {
    SQU_ST_IDLE = 3'b001,
    SQU_ST_WAIT = 3'b010,
    SQU_ST_FIN  = 3'b100
  } squ_fsm_type;

  typedef struct packed {
    logic        valid;
    logic [31:0] instr;
    logic [63:0] src_a;
    logic [63:0] src_b;
  } squ_issue_type;

  typedef struct packed {
    logic       is_legacy;
    logic       is_dword;
    logic       ovf_en;
    logic       record_bit;
    logic [4:0] target;
  } squ_dec_type;

  typedef struct packed {
    logic        valid;
    logic        illegal;
    logic        mq_wr;
    logic [4:0]  target;
    logic [63:0] data;
  } squ_result_type;

  typedef struct packed {
    logic        busy;
    logic        done;
    logic [6:0]  cnt;
    logic [63:0] rem;
    logic [63:0] quo;
    logic [63:0] dvs;
  } squ_div_state_type;

endpackage : squ_pkg

//--- verilog/squ_divider.sv
/*
  Unsigned 64-by-64 restoring divider, one quotient bit per clock.
  Assumes start is a one-cycle pulse given only while not busy.
*/
`timescale 1ns/1ps
`include "squ_defs.svh"
module squ_divider import squ_pkg::*; (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // Request
  input  wire logic        start,
  input  wire logic [63:0] dividend,
  input  wire logic [63:0] divisor,
  // Answer
  output logic             done,
  output logic [63:0]      quotient,
  output logic [63:0]      remainder
);

  squ_div_state_type q, d;
  logic [64:0]       trial;

  always_comb begin
    trial  = {q.rem, q.quo[63]} - {1'b0, q.dvs};
    d      = q;
    d.done = 1'b0;
    if (start) begin
      d.busy = 1'b1;
      d.cnt  = 7'h00;
      d.rem  = 64'h0;
      d.quo  = dividend;
      d.dvs  = divisor;
    end else if (q.busy) begin
      // No borrow: the divisor fits, keep the difference
      d.rem = trial[64] ? {q.rem[62:0], q.quo[63]} : trial[63:0];
      d.quo = {q.quo[62:0], ~trial[64]};
      d.cnt = q.cnt + 7'h01;
      if (q.cnt == `SQU_DIV_LAST) begin
        d.busy = 1'b0;
        d.done = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign done      = q.done;
  assign quotient  = q.quo;
  assign remainder = q.rem;

endmodule : squ_divider

//--- verilog/squ_decode.sv
/*
  Instruction decoder for the two signed divisions.
  Assumes a 32-bit instruction word, field bit 0 in word bit 31.
*/
`timescale 1ns/1ps
`include "squ_defs.svh"
module squ_decode import squ_pkg::*; (
  // Instruction
  input  wire logic [31:0] instr,
  // Decoded fields
  output squ_dec_type      dec
);

  logic primary_ok;
  logic [8:0] ext;

  assign primary_ok     = instr[`SQU_PRIMARY_HI:`SQU_PRIMARY_LO] == `SQU_PRIMARY_DIV;
  assign ext            = instr[`SQU_EXT_HI:`SQU_EXT_LO];
  assign dec.is_legacy  = primary_ok && (ext == `SQU_EXT_LEGACY);
  assign dec.is_dword   = primary_ok && (ext == `SQU_EXT_DWORD);
  assign dec.ovf_en     = instr[`SQU_OVF_EN_BIT];
  assign dec.record_bit = instr[`SQU_RECORD_BIT];
  assign dec.target     = instr[`SQU_TARGET_HI:`SQU_TARGET_LO];

endmodule : squ_decode

//--- verilog/squ_top.sv
/*
  Signed quotient unit: legacy 64-by-32 division through the multiply-
  quotient register and 64-bit doubleword division, with exception and
  condition flags, APB register access and one interrupt.
  Assumes issue logic holds a request until issue_ready and the register
  file writes result data on result.valid.
*/
`timescale 1ns/1ps
`include "squ_defs.svh"
module squ_top import squ_pkg::*; (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // Instruction issue
  input  squ_issue_type    issue,
  output logic             issue_ready,
  // Register file write-back
  output squ_result_type   result,
  // Architected state
  output logic [31:0]      multiply_quotient_register,
  output logic             summary_overflow_flag,
  output logic             overflow_flag,
  output logic             carry_flag,
  output logic [3:0]       condition_field_zero,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Interrupt
  output logic             irq
);

  typedef struct packed {
    squ_fsm_type    fsm;
    squ_dec_type    op;
    logic           sa;
    logic           sb;
    logic           b_zero;
    logic           special;
    squ_result_type res;
    logic [31:0]    mq;
    logic           so;
    logic           ov;
    logic           ca;
    logic [3:0]     cr0;
    logic           impl64;
    logic [2:0]     status;
    logic [2:0]     mask;
    logic           irq;
    logic [31:0]    prdata;
    logic           pready;
    logic           pslverr;
    logic           ready;
  } squ_top_state_type;

  squ_top_state_type q, d;
  squ_dec_type       dec;

  logic        div_start;
  logic [63:0] div_dvd;
  logic [63:0] div_dvs;
  logic        div_done;
  logic [63:0] div_quo;
  logic [63:0] div_rem;

  squ_decode u_decode (
    .instr (issue.instr),
    .dec   (dec)
  );

  squ_divider u_divider (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .start     (div_start),
    .dividend  (div_dvd),
    .divisor   (div_dvs),
    .done      (div_done),
    .quotient  (div_quo),
    .remainder (div_rem)
  );

  always_comb begin
    logic        take;
    logic        legal;
    logic [63:0] dvd;
    logic [63:0] dvs;
    logic [63:0] qs;
    logic [63:0] rs;
    logic [63:0] rt;
    logic        neg;
    logic        fits;
    logic        ovf;
    logic        setup;
    logic        wr;
    logic [2:0]  ev;
    logic [2:0]  w1c;
    take      = 1'b0;
    legal     = 1'b0;
    dvd       = 64'h0;
    dvs       = 64'h0;
    qs        = 64'h0;
    rs        = 64'h0;
    rt        = 64'h0;
    neg       = 1'b0;
    fits      = 1'b0;
    ovf       = 1'b0;
    ev        = 3'h0;
    w1c       = 3'h0;
    setup     = 1'b0;
    wr        = 1'b0;
    d         = q;
    d.res.valid   = 1'b0;
    d.res.illegal = 1'b0;
    d.res.mq_wr   = 1'b0;
    div_start = 1'b0;
    div_dvd   = 64'h0;
    div_dvs   = 64'h0;

    case (q.fsm)
      SQU_ST_IDLE: begin
        take  = issue.valid && q.ready;
        // Doubleword form exists only on 64-bit implementations
        legal = dec.is_legacy || (dec.is_dword && q.impl64);
        if (take && !legal) begin
          d.res.illegal = 1'b1;
          d.res.target  = dec.target;
          ev[`SQU_EV_ILLEGAL] = 1'b1;
        end else if (take) begin
          if (dec.is_legacy) begin
            dvd = {issue.src_a[31:0], q.mq};
            dvs = {{32{issue.src_b[31]}}, issue.src_b[31:0]};
            d.special = (dvd == {32'hffff_ffff, `SQU_MIN_WORD}) && (dvs == `SQU_ALL_ONES);
          end else begin
            dvd = issue.src_a;
            dvs = issue.src_b;
            d.special = (dvd == `SQU_MIN_DWORD) && (dvs == `SQU_ALL_ONES);
          end
          // Signs split off so one unsigned divider serves both forms
          d.op      = dec;
          d.sa      = dvd[63];
          d.sb      = dvs[63];
          d.b_zero  = dvs == 64'h0;
          div_start = 1'b1;
          div_dvd   = dvd[63] ? -dvd : dvd;
          div_dvs   = dvs[63] ? -dvs : dvs;
          d.ready   = 1'b0;
          d.fsm     = SQU_ST_WAIT;
        end
      end
      SQU_ST_WAIT: begin
        if (div_done) begin
          neg = q.sa ^ q.sb;
          // Negating a zero magnitude yields zero, so zero stays positive
          qs  = neg ? -div_quo : div_quo;
          rs  = q.sa ? -div_rem : div_rem;
          if (q.op.is_legacy) begin
            fits = (div_quo[63:31] == 33'h0) || (neg && (div_quo == {32'h0, `SQU_MIN_WORD}));
            ovf  = q.b_zero || !fits;
            if (q.special) begin
              rt   = {32'hffff_ffff, `SQU_MIN_WORD};
              d.mq = 32'h0;
            end else begin
              rt   = {{32{qs[31]}}, qs[31:0]};
              d.mq = rs[31:0];
            end
            d.res.mq_wr = 1'b1;
          end else begin
            ovf = q.b_zero || q.special;
            rt  = qs;
          end
          if (q.op.ovf_en) begin
            d.ov = ovf;
            d.so = q.so | ovf;
          end
          if (q.op.record_bit) begin
            d.cr0 = {rt[63], !rt[63] && (rt != 64'h0), rt == 64'h0, d.so};
          end
          d.res.valid  = 1'b1;
          d.res.target = q.op.target;
          d.res.data   = rt;
          ev[`SQU_EV_DONE] = 1'b1;
          ev[`SQU_EV_OVF]  = ovf;
          d.fsm = SQU_ST_FIN;
        end
      end
      SQU_ST_FIN: begin
        d.ready = 1'b1;
        d.fsm   = SQU_ST_IDLE;
      end
      default: begin
        d.ready = 1'b1;
        d.fsm   = SQU_ST_IDLE;
      end
    endcase

    // APB: answer prepared in setup, pready high in the first access cycle
    setup     = psel && !penable;
    wr        = psel && penable && q.pready && pwrite && !q.pslverr;
    d.pready  = setup;
    d.pslverr = 1'b0;
    if (setup) begin
      d.prdata = 32'h0;
      case (paddr)
        `SQU_ADDR_CTRL:   d.prdata[`SQU_CTRL_IMPL64] = q.impl64;
        `SQU_ADDR_STATUS: d.prdata[2:0] = q.status;
        `SQU_ADDR_MASK:   d.prdata[2:0] = q.mask;
        `SQU_ADDR_MQ:     d.prdata = q.mq;
        `SQU_ADDR_FLAGS:  d.prdata = {20'h0, q.cr0, 5'h0, q.ca, q.ov, q.so};
        `SQU_ADDR_RES_LO: d.prdata = q.res.data[31:0];
        `SQU_ADDR_RES_HI: d.prdata = q.res.data[63:32];
        default:          d.pslverr = 1'b1;
      endcase
    end
    if (wr) begin
      case (paddr)
        `SQU_ADDR_CTRL:   d.impl64 = pwdata[`SQU_CTRL_IMPL64];
        `SQU_ADDR_STATUS: w1c = pwdata[2:0];
        `SQU_ADDR_MASK:   d.mask = pwdata[2:0];
        // Writes from software lose to a legacy division completing this cycle
        `SQU_ADDR_MQ:     if (!d.res.mq_wr) d.mq = pwdata;
        `SQU_ADDR_FLAGS: begin
          d.ca = pwdata[`SQU_FL_CA];
          if (!(d.res.valid && q.op.ovf_en)) begin
            d.so = pwdata[`SQU_FL_SO];
            d.ov = pwdata[`SQU_FL_OV];
          end
          if (!(d.res.valid && q.op.record_bit)) begin
            d.cr0 = pwdata[`SQU_FL_CR0_HI:`SQU_FL_CR0_LO];
          end
        end
        default: w1c = 3'h0;
      endcase
    end
    // Hardware set wins over a clear in the same cycle
    d.status = (q.status & ~w1c) | ev;
    d.irq    = |(d.status & d.mask);
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      q        <= '0;
      q.fsm    <= SQU_ST_IDLE;
      q.impl64 <= `SQU_RST_IMPL64;
      q.mask   <= `SQU_RST_MASK;
      q.ready  <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign issue_ready                = q.ready;
  assign result                     = q.res;
  assign multiply_quotient_register = q.mq;
  assign summary_overflow_flag      = q.so;
  assign overflow_flag              = q.ov;
  assign carry_flag                 = q.ca;
  assign condition_field_zero       = q.cr0;
  assign prdata                     = q.prdata;
  assign pready                     = q.pready;
  assign pslverr                    = q.pslverr;
  assign irq                        = q.irq;

  logic apb_ca_wr;
  assign apb_ca_wr = psel && penable && q.pready && pwrite && (paddr == `SQU_ADDR_FLAGS);

  chk_carry_kept: assert property (
    @(posedge core_clk) disable iff (!nrst)
    !$past(apb_ca_wr) |-> $stable(q.ca))
    else $error("carry flag changed without a register write");

  chk_flags_untouched: assert property (
    @(posedge core_clk) disable iff (!nrst)
    q.res.valid && !q.op.ovf_en && !$past(apb_ca_wr) |-> $stable(q.so) && $stable(q.ov))
    else $error("overflow flags changed with overflow-enable clear");

  chk_cr0_untouched: assert property (
    @(posedge core_clk) disable iff (!nrst)
    q.res.valid && !q.op.record_bit && !$past(apb_ca_wr) |-> $stable(q.cr0))
    else $error("condition field changed with record bit clear");

  chk_min_word: assert property (
    @(posedge core_clk) disable iff (!nrst)
    q.res.valid && q.op.is_legacy && q.special
      |-> q.mq == 32'h0 && q.res.data == 64'hffff_ffff_8000_0000)
    else $error("minimum word over minus one gave wrong result");

  chk_rem_sign: assert property (
    @(posedge core_clk) disable iff (!nrst)
    q.res.valid && q.op.is_legacy && !q.b_zero && !q.special && q.mq != 32'h0 && !q.status[`SQU_EV_OVF]
      |-> q.mq[31] == q.sa)
    else $error("remainder sign differs from dividend sign");

  chk_dword_ovf: assert property (
    @(posedge core_clk) disable iff (!nrst)
    q.res.valid && q.op.is_dword && q.op.ovf_en && (q.b_zero || q.special) |-> q.ov && q.so)
    else $error("doubleword overflow did not set overflow");

  chk_quot_sign: assert property (
    @(posedge core_clk) disable iff (!nrst)
    q.res.valid && q.op.is_dword && !q.b_zero && !q.special && q.res.data != 64'h0
      |-> q.res.data[63] == (q.sa ^ q.sb))
    else $error("doubleword quotient sign wrong");

  chk_illegal_dword: assert property (
    @(posedge core_clk) disable iff (!nrst)
    issue.valid && q.ready && q.fsm == SQU_ST_IDLE && dec.is_dword && !q.impl64
      |=> q.res.illegal && !q.res.valid && q.ready)
    else $error("doubleword accepted on a 32-bit implementation");

  chk_latency: assert property (
    @(posedge core_clk) disable iff (!nrst)
    $rose(q.fsm == SQU_ST_WAIT) |-> ##65 q.res.valid)
    else $error("division did not complete in 65 cycles");

  cov_legacy: cover property (@(posedge core_clk) disable iff (!nrst) q.res.valid && q.op.is_legacy);
  cov_dword: cover property (@(posedge core_clk) disable iff (!nrst) q.res.valid && q.op.is_dword);
  cov_illegal: cover property (@(posedge core_clk) disable iff (!nrst) q.res.illegal);
  cov_irq: cover property (@(posedge core_clk) disable iff (!nrst) $rose(q.irq));

endmodule : squ_top

//--- verification/squ_issue_model.sv
/*
  Stand-in for the core's decode and register-file logic: offers one divide
  request at a time, holds it until taken, and keeps the last write-back.
  Assumes squ_pkg is compiled first and requests come from one process.
*/
`timescale 1ns/1ps
module squ_issue_model import squ_pkg::*; (
  // Clock
  input  wire logic      core_clk,
  // Issue side
  output squ_issue_type  issue,
  input  wire logic      issue_ready,
  // Write-back side
  input  squ_result_type result
);
  squ_result_type res_q;
  int             wait_n;

  initial begin
    issue = '0;
  end

  task automatic send(input logic [31:0] instr, input logic [63:0] a, input logic [63:0] b, input int idle);
    res_q = '0;
    repeat (idle) @(posedge core_clk);
    issue <= '{valid: 1'b1, instr: instr, src_a: a, src_b: b};
    wait_n = 0;
    do begin
      @(posedge core_clk);
      wait_n++;
    end while (issue_ready !== 1'b1);
    // Released fields flip so stale operands cannot pass for held ones
    issue <= '{valid: 1'b0, instr: ~instr, src_a: ~a, src_b: ~b};
    wait_n = 0;
    do begin
      @(posedge core_clk);
      wait_n++;
    end while (result.valid !== 1'b1 && result.illegal !== 1'b1);
    res_q = result;
  endtask : send

endmodule : squ_issue_model

//--- verification/squ_tb.sv
/*
  Self-checking bench of the signed quotient unit: APB registers, legacy and
  doubleword divisions, flags, illegal requests and the interrupt.
  Assumes squ_defs.svh on the include path and squ_pkg compiled first.
*/
`timescale 1ns/1ps
`include "squ_defs.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_errors++; $display("FAIL %s exp %0h got %0h", nm, e, g); end end
module signed_quotient_unit_tb import squ_pkg::*; ;
  logic           core_clk, nrst;
  squ_issue_type  issue;
  logic           issue_ready;
  squ_result_type result;
  logic [31:0]    mq, mq_keep;
  logic           so, ov, ca, irq;
  logic [3:0]     cr0;
  logic           psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]     paddr;
  logic [31:0]    pwdata, prdata, rd;
  int             n_errors, compares, cycles;
  logic [63:0]    dw_a [3] = '{64'hffff_ffff_ffff_fff9, 64'h7, 64'hffff_ffff_ffff_fff8};
  logic [63:0]    dw_b [3] = '{64'h2, 64'hffff_ffff_ffff_fffe, 64'hffff_ffff_ffff_fffe};
  logic [63:0]    dw_q [3] = '{64'hffff_ffff_ffff_fffd, 64'hffff_ffff_ffff_fffd, 64'h4};
  logic [3:0]     dw_c [3] = '{4'h9, 4'h9, 4'h5};

  squ_top dut_u (
    .core_clk(core_clk), .nrst(nrst), .issue(issue), .issue_ready(issue_ready), .result(result),
    .multiply_quotient_register(mq), .summary_overflow_flag(so), .overflow_flag(ov), .carry_flag(ca),
    .condition_field_zero(cr0), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

  squ_issue_model partner_u (.core_clk(core_clk), .issue(issue), .issue_ready(issue_ready), .result(result));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic finish_test();
    if (n_errors == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test

  // Whole run is about 800 cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      finish_test();
    end
  end

  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic div(input logic [8:0] ext, input logic oe, input logic rc,
                     input logic [63:0] a, input logic [63:0] b, input logic [31:0] mq_in);
    if (ext == `SQU_EXT_LEGACY) begin
      apb(1'b1, `SQU_ADDR_MQ, mq_in);
    end
    partner_u.send({`SQU_PRIMARY_DIV, 5'h07, 10'h000, oe, ext, rc}, a, b, 0);
  endtask : div

  initial begin
    n_errors = 0;
    compares = 0;
    cycles = 0;
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    repeat (10) @(posedge core_clk);
    nrst <= 1'b1;
    apb(1'b0, `SQU_ADDR_CTRL, '0);
    `CHK("ctrl reset", 32'h1, rd)
    apb(1'b0, `SQU_ADDR_MASK, '0);
    `CHK("mask reset", 32'h0, rd)
    apb(1'b0, 8'h1c, '0);
    `CHK("hole err", 1'b1, err)
    `CHK("hole data", 32'h0, rd)
    apb(1'b1, `SQU_ADDR_FLAGS, 32'h4);
    apb(1'b1, `SQU_ADDR_MASK, 32'h1);
    // Zero quotient, record set
    div(`SQU_EXT_LEGACY, 1'b0, 1'b1, 64'h0, 64'h2, 32'h1);
    `CHK("legacy q", 64'h0, partner_u.res_q.data)
    `CHK("legacy wb", 7'h67, {partner_u.res_q.valid, partner_u.res_q.mq_wr, partner_u.res_q.target})
    `CHK("legacy mq", 32'h1, mq)
    `CHK("cr0 zero", 4'h2, cr0)
    apb(1'b0, `SQU_ADDR_MQ, '0);
    `CHK("mq reg", 32'h1, rd)
    `CHK("irq on", 1'b1, irq)
    apb(1'b1, `SQU_ADDR_STATUS, 32'h1);
    apb(1'b0, `SQU_ADDR_STATUS, '0);
    `CHK("status clr", 32'h0, rd)
    `CHK("irq off", 1'b0, irq)
    apb(1'b1, `SQU_ADDR_MASK, 32'h0);
    // Negative dividend; upper source bits must be ignored
    div(`SQU_EXT_LEGACY, 1'b1, 1'b1, 64'h1234_5678_ffff_ffff, 64'h2, 32'hffff_fff9);
    `CHK("neg q", 64'hffff_ffff_ffff_fffd, partner_u.res_q.data)
    `CHK("neg rem", 32'hffff_ffff, mq)
    `CHK("neg cr0", 4'h8, cr0)
    `CHK("neg xer", 2'b00, {so, ov})
    `CHK("irq masked", 1'b0, irq)
    // Most negative word over minus one, record clear
    div(`SQU_EXT_LEGACY, 1'b1, 1'b0, 64'hffff_ffff, 64'hffff_ffff, 32'h8000_0000);
    `CHK("min q", 64'hffff_ffff_8000_0000, partner_u.res_q.data)
    `CHK("min mq", 32'h0, mq)
    `CHK("min xer", 2'b11, {so, ov})
    `CHK("min cr0", 4'h8, cr0)
    div(`SQU_EXT_LEGACY, 1'b1, 1'b1, 64'h0, 64'h3, 32'h6);
    `CHK("exact q", 64'h2, partner_u.res_q.data)
    `CHK("exact rem", 32'h0, mq)
    `CHK("exact xer", 2'b10, {so, ov})
    `CHK("exact cr0", 4'h5, cr0)
    // Zero divisor with overflow reporting off
    div(`SQU_EXT_LEGACY, 1'b0, 1'b0, 64'h0, 64'h0, 32'h1);
    `CHK("oe off xer", 2'b10, {so, ov})
    `CHK("carry kept", 1'b1, ca)
    apb(1'b0, `SQU_ADDR_STATUS, '0);
    `CHK("ovf status", 32'h3, rd)
    mq_keep = mq;
    div(`SQU_EXT_DWORD, 1'b1, 1'b0, `SQU_MIN_DWORD, `SQU_ALL_ONES, 32'h0);
    `CHK("dw min ov", 1'b1, ov)
    for (int i = 0; i < 3; i++) begin
      div(`SQU_EXT_DWORD, 1'b1, 1'b1, dw_a[i], dw_b[i], 32'h0);
      `CHK("dw q", dw_q[i], partner_u.res_q.data)
      `CHK("dw mq_wr", 1'b0, partner_u.res_q.mq_wr)
      `CHK("dw ov", 1'b0, ov)
      `CHK("dw cr0", dw_c[i], cr0)
    end
    `CHK("dw mq kept", mq_keep, mq)
    div(`SQU_EXT_DWORD, 1'b1, 1'b0, 64'h5, 64'h0, 32'h0);
    `CHK("dw zero ov", 1'b1, ov)
    // Doubleword refused on a 32-bit implementation
    apb(1'b1, `SQU_ADDR_CTRL, 32'h0);
    apb(1'b1, `SQU_ADDR_STATUS, 32'h7);
    div(`SQU_EXT_DWORD, 1'b0, 1'b0, 64'h9, 64'h3, 32'h0);
    `CHK("dw illegal", 2'b01, {partner_u.res_q.valid, partner_u.res_q.illegal})
    apb(1'b0, `SQU_ADDR_STATUS, '0);
    `CHK("ill status", 32'h4, rd)
    partner_u.send({`SQU_PRIMARY_DIV, 5'h07, 11'h000, 9'h1c9, 1'b0}, 64'h9, 64'h3, 2);
    `CHK("other ext", 2'b01, {partner_u.res_q.valid, partner_u.res_q.illegal})
    partner_u.send({6'h00, 5'h07, 11'h000, `SQU_EXT_LEGACY, 1'b0}, 64'h9, 64'h3, 0);
    `CHK("other op", 2'b01, {partner_u.res_q.valid, partner_u.res_q.illegal})
    finish_test();
  end

endmodule : signed_quotient_unit_tb
